// file: inc/lsh_pkg.sv
// lsh_pkg: constants shared by the lin slave header checker.
// assumes a 50 MHz aclk and a 32-bit axi4-lite register port.
package lsh_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_DATA    = 8'h04;
   localparam logic [7:0] OFS_CTRL2   = 8'h08;
   localparam logic [7:0] OFS_CTRL3   = 8'h0c;
   localparam logic [7:0] OFS_DIVMANT = 8'h10;
   localparam logic [7:0] OFS_DIVFRAC = 8'h14;
   localparam logic [7:0] OFS_HDRLEN  = 8'h18;
   // status fields
   localparam int ST_RXFULL  = 5;
   localparam int ST_OVERRUN = 4;
   localparam int ST_HDRERR  = 3;
   localparam int ST_FRMERR  = 1;
   // control 2 fields
   localparam int C2_RIE = 5;
   localparam int C2_RWU = 1;
   // control 3 fields
   localparam int C3_LINEN = 0;
   localparam int C3_SLV   = 1;
   localparam int C3_HDM   = 2;
   localparam int C3_ARS   = 3;
   localparam int C3_SFS   = 4;
   localparam int C3_DIVIDER_UPDATE_METHOD  = 5;
   localparam int C3_HDF   = 6;
   // reset values
   localparam logic [7:0]  RST_CTRL   = 8'h00;
   localparam logic [11:0] RST_DIV    = 12'h000;
   // protocol figures
   localparam logic [7:0]  SYNC_BYTE    = 8'h55;
   localparam logic [3:0]  BREAK_BITS   = 4'hb;
   localparam logic [3:0]  CHAR_LOW     = 4'ha;
   localparam logic [7:0]  HDR_MAX_BITS = 8'h39;
   localparam logic [12:0] OVS_STEP     = 13'h0010;
   localparam logic [3:0]  MID_SAMPLE   = 4'h7;
   localparam logic [2:0]  SYNC_EDGES   = 3'h4;
   // deviation limits in 128ths: flag at 21/128, bit-time floor 107/128
   localparam logic [4:0]  DEV_LIMIT    = 5'h15;
   localparam logic [7:0]  BIT_FLOOR    = 8'hd6;
   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRK, RX_MEAS, RX_SKIP
   } lsh_rx_e;
   typedef enum logic [1:0] {HP_NONE, HP_SYNC, HP_ID} lsh_hp_e;
endpackage

// file: hw/lsh_lin_slave.sv
// lsh_lin_slave: lin slave receive path with header checks and auto baud.
// assumes rx_pin is asynchronous; the cpu interrupt mask bits arrive on aclk.
`timescale 1ns/1ps
module lsh_lin_slave
   import lsh_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   // axi4-lite write response
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial line and cpu side
   input  wire logic        rx_pin,
   input  wire logic [1:0]  irq_mask_bits,
   output      logic        rx_irq_req,
   output      logic        rate_tick
);
   // axi state
   logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   // control and status
   logic        rie_q, rwu_q, linen_q, slv_q, hdm_q, ars_q, sfs_q, divider_update_method_q, hdf_q;
   logic        hef_q, fef_q, ovr_q, rxfull_q, armed_q;
   logic [7:0]  rxdata_q, hdrlen_q;
   logic [11:0] nom_q, meas_q, baud_divider_q;
   // receiver
   logic        rxd_s1_q, rxd_s2_q, rxd_q;
   logic [12:0] acc_q;
   lsh_rx_e     rx_q;
   lsh_hp_e     hp_q;
   logic [3:0]  scnt_q, lowbits_q, tsub_q;
   logic [2:0]  bit_q, edge_q;
   logic [7:0]  shift_q;
   logic [14:0] mcnt_q, prev_q;
   logic        tmr_q;

   // bus decode
   wire        lin_mode  = linen_q & slv_q;
   wire        wr_go     = aw_full_q & w_full_q & ~bvalid_q;
   wire        rd_go     = s_axi_arvalid & ~rvalid_q;
   wire        wr_b0     = wr_go & wstrb_q[0];
   wire        wr_ctrl2  = wr_b0 & (awaddr_q == OFS_CTRL2);
   wire        wr_ctrl3  = wr_b0 & (awaddr_q == OFS_CTRL3);
   wire        wr_mant   = wr_b0 & (awaddr_q == OFS_DIVMANT);
   wire        wr_frac   = wr_b0 & (awaddr_q == OFS_DIVFRAC);
   wire        wr_map    = (awaddr_q[7:2] <= OFS_HDRLEN[7:2]) & (awaddr_q[1:0] == 2'h0);
   wire        rd_map    = (s_axi_araddr[7:2] <= OFS_HDRLEN[7:2]) & (s_axi_araddr[1:0] == 2'h0);
   wire        rd_status = rd_go & (s_axi_araddr == OFS_STATUS);
   wire        rd_data   = rd_go & (s_axi_araddr == OFS_DATA);
   wire        sw_sfs_clr = wr_ctrl3 & ~wdata_q[C3_SFS] & sfs_q;

   wire [7:0]  status_v = {2'h0, rxfull_q, ovr_q, hef_q, 1'b0, fef_q, 1'b0};
   wire [7:0]  ctrl2_v  = {2'h0, rie_q, 3'h0, rwu_q, 1'b0};
   wire [7:0]  ctrl3_v  = {1'b0, hdf_q, divider_update_method_q, sfs_q, ars_q, hdm_q, slv_q, linen_q};
   // divider update method 1 shows the nominal value, 0 the active one
   wire [11:0] div_rd   = divider_update_method_q ? nom_q : baud_divider_q;
   wire [7:0]  rd_byte  =
      (s_axi_araddr == OFS_STATUS)  ? status_v :
      (s_axi_araddr == OFS_DATA)    ? rxdata_q :
      (s_axi_araddr == OFS_CTRL2)   ? ctrl2_v :
      (s_axi_araddr == OFS_CTRL3)   ? ctrl3_v :
      (s_axi_araddr == OFS_DIVMANT) ? div_rd[11:4] :
      (s_axi_araddr == OFS_DIVFRAC) ? {4'h0, div_rd[3:0]} :
      (s_axi_araddr == OFS_HDRLEN)  ? hdrlen_q : 8'h00;

   assign s_axi_awready = ~aw_full_q & ~bvalid_q;
   assign s_axi_wready  = ~w_full_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // 16x sample tick: fractional accumulator, one generator for the receiver and rate_tick
   wire [12:0] acc_sum   = acc_q + OVS_STEP;
   wire        div_ok    = lin_mode & (baud_divider_q != RST_DIV);
   wire        samp_tick = div_ok & (acc_sum >= {1'b0, baud_divider_q});
   assign rate_tick = samp_tick;

   // serial line events
   wire        fall     = rxd_q & ~rxd_s2_q;
   wire        bit_end  = samp_tick & (scnt_q == 4'hf);
   wire        stop_end = (rx_q == RX_STOP) & bit_end;
   wire        is_brk_chr = stop_end & (shift_q == 8'h00) & ~rxd_s2_q;
   wire        chr_done = (stop_end & ~is_brk_chr)
                        | ((rx_q == RX_BRK) & rxd_s2_q & (lowbits_q < BREAK_BITS));
   wire        chr_fe   = (rx_q == RX_BRK) | ~rxd_s2_q;
   wire        brk_det  = (rx_q == RX_BRK) & rxd_s2_q & (lowbits_q >= BREAK_BITS);

   // synch measurement checks
   wire [14:0] nom_cnt  = {baud_divider_q, 3'h0};
   wire [14:0] dif_cnt  = (mcnt_q >= nom_cnt) ? mcnt_q - nom_cnt : nom_cnt - mcnt_q;
   wire [21:0] dev_lhs  = {dif_cnt, 7'h00};
   wire [21:0] dev_rhs  = 22'(nom_cnt * DEV_LIMIT);
   wire [14:0] intv     = mcnt_q - prev_q;
   wire [21:0] bit_lhs  = {intv, 7'h00};
   wire [21:0] bit_rhs  = 22'(baud_divider_q * BIT_FLOOR);
   wire        meas_on  = (rx_q == RX_MEAS) & (edge_q != 3'h0);
   wire        meas_ovf = meas_on & (mcnt_q == 15'h7fff);
   wire        edge_n   = (rx_q == RX_MEAS) & fall & (edge_q != 3'h0);
   wire        bit_short = edge_n & (bit_lhs < bit_rhs);
   wire        last_edge = edge_n & (edge_q == SYNC_EDGES);
   wire        dev_big  = last_edge & (dev_lhs >= dev_rhs);
   wire        meas_err = meas_ovf | bit_short | dev_big;
   wire        meas_ok  = last_edge & ~meas_err;

   // header sequencing
   wire        tmr_en    = hdm_q | ars_q;
   wire        tmr_bit   = tmr_q & samp_tick & (tsub_q == 4'hf);
   wire        tout      = tmr_bit & (hdrlen_q >= HDR_MAX_BITS);
   wire        tout_blk  = tout & (hp_q == HP_SYNC) & ars_q;
   wire        sync_chr  = chr_done & (hp_q == HP_SYNC) & ~ars_q;
   wire        sync_bad  = sync_chr & (shift_q != SYNC_BYTE);
   wire        id_chr    = chr_done & (hp_q == HP_ID);
   wire        id_wake   = id_chr & hdm_q & ~chr_fe & rwu_q;
   // identifier mode holds back the synch byte; only the identifier is handed over
   wire        xfer      = chr_done & ~rwu_q & ~(hdm_q & (hp_q != HP_NONE))
                         | id_chr & hdm_q & (~rwu_q | id_wake);
   // break-only mode hands the break itself to software
   wire        brk_xfer  = brk_det & ~hdm_q & (~rwu_q | ~ars_q);
   wire        overrun   = (xfer | brk_xfer) & rxfull_q;
   wire        hdr_err   = sync_bad | meas_err | tout | overrun;
   // a data read after a status access clears; synch state must go first
   wire        seq_clr   = rd_data & armed_q;
   wire        clr_hef   = seq_clr & ~sfs_q;
   wire        tmr_stop  = id_chr | sync_bad | meas_err | overrun | tout
                         | (sw_sfs_clr & (hp_q == HP_SYNC));

   assign rx_irq_req = rie_q & (irq_mask_bits == 2'h0)
                     & (hef_q | rxfull_q | ovr_q | hdf_q);

   // axi handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bresp_q   <= RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rie_q   <= RST_CTRL[C2_RIE];
         rwu_q   <= RST_CTRL[C2_RWU];
         linen_q <= RST_CTRL[C3_LINEN];
         slv_q   <= RST_CTRL[C3_SLV];
         hdm_q   <= RST_CTRL[C3_HDM];
         ars_q   <= RST_CTRL[C3_ARS];
         divider_update_method_q  <= RST_CTRL[C3_DIVIDER_UPDATE_METHOD];
      end else begin
         if (wr_ctrl2) begin
            rie_q <= wdata_q[C2_RIE];
            rwu_q <= wdata_q[C2_RWU];
         end else if (id_wake || (brk_det && !hdm_q && !ars_q)) begin
            rwu_q <= 1'b0;
         end else if (meas_ok && !hdm_q) begin
            rwu_q <= 1'b0;
         end
         if (wr_ctrl3) begin
            linen_q <= wdata_q[C3_LINEN];
            slv_q   <= wdata_q[C3_SLV];
            hdm_q   <= wdata_q[C3_HDM];
            ars_q   <= wdata_q[C3_ARS];
            divider_update_method_q  <= wdata_q[C3_DIVIDER_UPDATE_METHOD];
         end
      end
   end

   // status flags: a hardware set beats the software clear, except rxfull, which a data read clears even as a character arrives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hef_q    <= 1'b0;
         fef_q    <= 1'b0;
         ovr_q    <= 1'b0;
         rxfull_q <= 1'b0;
         hdf_q    <= 1'b0;
         armed_q  <= 1'b0;
         rxdata_q <= 8'h00;
         sfs_q    <= 1'b0;
      end else begin
         if (rd_status) begin
            armed_q <= 1'b1;
         end else if (rd_data) begin
            armed_q <= 1'b0;
         end
         if (hdr_err) begin
            hef_q <= 1'b1;
         end else if (clr_hef) begin
            hef_q <= 1'b0;
         end
         if (overrun) begin
            ovr_q <= 1'b1;
         end else if (seq_clr) begin
            ovr_q <= 1'b0;
         end
         if (xfer && chr_fe && !rwu_q) begin
            fef_q <= 1'b1;
         end else if (seq_clr) begin
            fef_q <= 1'b0;
         end
         if ((xfer || brk_xfer) && !rxfull_q) begin
            rxfull_q <= 1'b1;
            rxdata_q <= brk_xfer ? 8'h00 : shift_q;
         end else if (rd_data) begin
            rxfull_q <= 1'b0;
         end
         if ((brk_det && !hdm_q) || (id_chr && hdm_q && (!rwu_q || id_wake))) begin
            hdf_q <= 1'b1;
         end else if (rd_data) begin
            hdf_q <= 1'b0;
         end
         if ((brk_det && ars_q) || meas_ovf || meas_err || tout_blk) begin
            sfs_q <= 1'b1;
         end else if (meas_ok || sw_sfs_clr) begin
            sfs_q <= 1'b0;
         end
      end
   end

   // divider set: nominal, measured and active
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nom_q  <= RST_DIV;
         meas_q <= RST_DIV;
         baud_divider_q <= RST_DIV;
         acc_q  <= 13'h0000;
      end else begin
         if (!div_ok) begin
            acc_q <= 13'h0000;
         end else if (samp_tick) begin
            acc_q <= acc_sum - {1'b0, baud_divider_q};
         end else begin
            acc_q <= acc_sum;
         end
         if (wr_frac) begin
            nom_q[3:0] <= wdata_q[3:0];
         end
         if (wr_mant) begin
            nom_q[11:4] <= wdata_q[7:0];
         end
         if (last_edge) begin
            meas_q <= mcnt_q[14:3];
         end
         // method 0 loads on the mantissa write; method 1 at the next break
         if (wr_mant && !divider_update_method_q) begin
            baud_divider_q <= {wdata_q[7:0], nom_q[3:0]};
         end else if (meas_ok && ars_q) begin
            baud_divider_q <= mcnt_q[14:3];
         end else if (brk_det && divider_update_method_q) begin
            baud_divider_q <= nom_q;
         end
      end
   end

   // header timer and phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmr_q    <= 1'b0;
         tsub_q   <= 4'h0;
         hdrlen_q <= 8'h00;
         hp_q     <= HP_NONE;
      end else begin
         if (brk_det) begin
            tmr_q    <= tmr_en;
            tsub_q   <= 4'h0;
            hdrlen_q <= 8'h00;
         end else if (tmr_stop) begin
            tmr_q <= 1'b0;
         end else if (tmr_q && samp_tick) begin
            tsub_q <= tsub_q + 4'h1;
            if (tsub_q == 4'hf) begin
               hdrlen_q <= hdrlen_q + 8'h01;
            end
         end
         if (brk_det) begin
            hp_q <= HP_SYNC;
         end else if (tout || sync_bad || meas_err || id_chr || sw_sfs_clr) begin
            hp_q <= HP_NONE;
         end else if (meas_ok || (sync_chr && !sync_bad)) begin
            hp_q <= HP_ID;
         end
      end
   end

   // serial receiver with break and synch measurement
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxd_s1_q  <= 1'b1;
         rxd_s2_q  <= 1'b1;
         rxd_q     <= 1'b1;
         rx_q      <= RX_IDLE;
         scnt_q    <= 4'h0;
         bit_q     <= 3'h0;
         shift_q   <= 8'h00;
         lowbits_q <= 4'h0;
         edge_q    <= 3'h0;
         mcnt_q    <= 15'h0000;
         prev_q    <= 15'h0000;
      end else begin
         rxd_s1_q <= rx_pin;
         rxd_s2_q <= rxd_s1_q;
         rxd_q    <= rxd_s2_q;
         if (samp_tick) begin
            scnt_q <= scnt_q + 4'h1;
         end
         if (tout_blk || (sw_sfs_clr && rx_q == RX_MEAS)) begin
            rx_q <= RX_IDLE;
         end else begin
            unique case (rx_q)
               RX_IDLE: begin
                  // blocked synch state holds reception off
                  if (fall && div_ok && !sfs_q) begin
                     rx_q   <= RX_START;
                     scnt_q <= 4'h0;
                  end
               end
               RX_START: begin
                  if (samp_tick && scnt_q == MID_SAMPLE) begin
                     rx_q   <= rxd_s2_q ? RX_IDLE : RX_DATA;
                     scnt_q <= 4'h0;
                     bit_q  <= 3'h0;
                  end
               end
               RX_DATA: begin
                  if (bit_end) begin
                     shift_q <= {rxd_s2_q, shift_q[7:1]};
                     bit_q   <= bit_q + 3'h1;
                     if (bit_q == 3'h7) begin
                        rx_q <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (is_brk_chr) begin
                     rx_q      <= RX_BRK;
                     lowbits_q <= CHAR_LOW;
                  end else if (stop_end) begin
                     rx_q <= RX_IDLE;
                  end
               end
               RX_BRK: begin
                  if (rxd_s2_q) begin
                     rx_q   <= (lowbits_q >= BREAK_BITS && ars_q) ? RX_MEAS : RX_IDLE;
                     edge_q <= 3'h0;
                     mcnt_q <= 15'h0000;
                     prev_q <= 15'h0000;
                  end else if (bit_end && lowbits_q != 4'hf) begin
                     lowbits_q <= lowbits_q + 4'h1;
                  end
               end
               RX_MEAS: begin
                  // character reception stays off until the fifth edge
                  if (meas_on && !meas_ovf) begin
                     mcnt_q <= mcnt_q + 15'h0001;
                  end
                  if (meas_err) begin
                     rx_q <= RX_IDLE;
                  end else if (fall) begin
                     edge_q <= edge_q + 3'h1;
                     prev_q <= mcnt_q;
                     // the first edge cycle counts too, so eight bits read as eight bit times
                     if (edge_q == 3'h0) begin
                        mcnt_q <= 15'h0001;
                     end
                     if (last_edge) begin
                        rx_q <= RX_SKIP;
                     end
                  end
               end
               RX_SKIP: begin
                  if (rxd_s2_q) begin
                     rx_q <= RX_IDLE;
                  end
               end
            endcase
         end
      end
   end
endmodule // lsh_lin_slave

// file: sim/lsh_lin_slave_properties.sv
// lsh_chk: port-level checks of the lin slave header block.
// assumes it is bound to lsh_lin_slave and sees only its ports.
`timescale 1ns/1ps
module lsh_chk
   import lsh_pkg::*;
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // cpu side
   input wire logic [1:0]  irq_mask_bits,
   input wire logic        rx_irq_req,
   input wire logic        rate_tick
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_irq_masked: assert property (|irq_mask_bits |-> !rx_irq_req)
      else $error("irq while masked");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !rx_irq_req && !rate_tick)
      else $error("output active after reset");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
endmodule // lsh_chk

bind lsh_lin_slave lsh_chk chk (.*);

// file: sim/lsh_lin_master.sv
// lsh_lin_master: behavioural lin master node driving the slave's serial line.
// assumes the line idles recessive high through its pull-up.
`timescale 1ns/1ps
module lsh_lin_master (
   input  wire logic aclk,
   output      logic line
);
   // bit time in clocks; the bench skews it to model master oscillator drift
   int bt = 32;
   initial line = 1'b1;
   task automatic hold(input logic v, input int n);
      line <= v;
      repeat (n * bt) @(posedge aclk);
   endtask
   task automatic send(input logic [7:0] b);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) hold(b[i], 1);
      hold(1'b1, 1);
   endtask
   task automatic brk;
      hold(1'b0, 13);
      hold(1'b1, 1);
   endtask
endmodule // lsh_lin_master

// file: sim/lsh_lin_slave_header_check_baud_tb.sv
// lsh_lin_slave_header_check_baud_tb: self-checking bench of the lin slave header block.
// assumes lsh_pkg, the checker and the lin master model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: %h not %h", $time, g, e); end end
module lsh_lin_slave_header_check_baud_tb;
   import lsh_pkg::*;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic        awr, wrd, bv, arr, rv, rx, irq, tick;
   logic [1:0]  bresp, rresp, be, msk = 0;
   logic [1:0]  bnotes[$];
   logic [7:0]  awa = 0, ara = 0, sb;
   logic [31:0] wd = 0, rdata, seed = 32'h1148;
   logic [67:0] notes[$];
   logic [67:0] nt;
   int          bad_count = 0, compares = 0, cyc = 0, n;
   always #10 aclk = ~aclk;
   lsh_lin_master master (.aclk(aclk), .line(rx));
   lsh_lin_slave DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .rx_pin(rx),
      .irq_mask_bits(msk), .rx_irq_req(irq), .rate_tick(tick));
   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic stop_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      bnotes.push_back((a > OFS_HDRLEN) ? RESP_SLVERR : RESP_OKAY);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
         if (bry && bv) bry <= 1'b0;
      end while (awv || wv || bry);
      // one idle edge so a following call never drives a strobe twice in one step
      @(posedge aclk);
   endtask
   // a mask lets status reads ignore bits that a scenario does not pin down
   task automatic rreg(input logic [7:0] a, input logic [1:0] r, input logic [7:0] d,
                       input logic [7:0] m);
      notes.push_back({2'b11, 24'hffffff, m, r, 24'h0, d & m});
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 1'b0;
         if (rry && rv) rry <= 1'b0;
      end while (arv || rry);
      @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (rv && rry && notes.size() > 0) begin
         nt = notes.pop_front();
         `CHK({rresp, rdata} & nt[67:34], nt[33:0])
      end
      if (bv && bry && bnotes.size() > 0) begin
         be = bnotes.pop_front();
         `CHK(bresp, be)
      end
      if (cyc == 40000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rreg(OFS_CTRL3, RESP_OKAY, RST_CTRL, 8'hff);
      rreg(OFS_DIVMANT, RESP_OKAY, RST_DIV[11:4], 8'hff);
      rreg(8'h1c, RESP_SLVERR, 8'h00, 8'hff);
      wreg(8'h1c, 8'hff);
      wreg(OFS_CTRL3, 8'h03);
      for (int i = 0; i < 2; i++) begin
         wreg(OFS_DIVFRAC, i ? 8'h00 : 8'h08);
         wreg(OFS_DIVMANT, i ? 8'h02 : 8'h01);
         n = 0;
         repeat (48) begin
            @(posedge aclk);
            n += tick;
         end
         `CHK(n, i ? 24 : 32)
      end
      wreg(OFS_CTRL2, 8'h20);
      master.brk();
      rreg(OFS_DATA, RESP_OKAY, 8'h00, 8'hff);
      seed = step(seed);
      sb = seed[7:0] | 8'h80;
      master.send(sb);
      rreg(OFS_STATUS, RESP_OKAY, 8'h28, 8'hff);
      `CHK(irq, 1'b1)
      rreg(OFS_DATA, RESP_OKAY, sb, 8'hff);
      rreg(OFS_STATUS, RESP_OKAY, 8'h00, 8'hff);
      wreg(OFS_CTRL3, 8'h07);
      master.brk();
      repeat (60 * 32) @(posedge aclk);
      rreg(OFS_STATUS, RESP_OKAY, 8'h08, 8'hff);
      rreg(OFS_HDRLEN, RESP_OKAY, HDR_MAX_BITS, 8'hff);
      rreg(OFS_DATA, RESP_OKAY, 8'h00, 8'h00);
      master.brk();
      master.send(SYNC_BYTE);
      master.send(8'h3c);
      rreg(OFS_STATUS, RESP_OKAY, 8'h20, 8'hff);
      rreg(OFS_DATA, RESP_OKAY, 8'h3c, 8'hff);
      wreg(OFS_CTRL3, 8'h0f);
      for (int i = 0; i < 2; i++) begin
         master.bt = i ? 44 : 36;
         master.brk();
         master.send(SYNC_BYTE);
         master.send(8'h3c);
         rreg(OFS_STATUS, RESP_OKAY, i ? 8'h08 : 8'h20, i ? 8'h08 : 8'h28);
      end
      rreg(OFS_CTRL3, RESP_OKAY, 8'h10, 8'h10);
      rreg(OFS_DIVMANT, RESP_OKAY, 8'h02, 8'hff);
      rreg(OFS_DIVFRAC, RESP_OKAY, 8'h04, 8'h0f);
      seed = step(seed);
      msk <= seed[1:0] | 2'b01;
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      msk <= 2'b00;
      for (int i = 0; i < 2; i++) begin
         if (i) wreg(OFS_CTRL3, 8'h0f);
         rreg(OFS_STATUS, RESP_OKAY, 8'h00, 8'h00);
         rreg(OFS_DATA, RESP_OKAY, 8'h00, 8'h00);
         rreg(OFS_STATUS, RESP_OKAY, i ? 8'h00 : 8'h08, 8'h08);
      end
      // update method 1 shows the nominal divider, not the measured one
      wreg(OFS_CTRL3, 8'h23);
      rreg(OFS_DIVFRAC, RESP_OKAY, 8'h00, 8'h0f);
      stop_test();
   end
endmodule // lsh_lin_slave_header_check_baud_tb
